// ===== tx_line_pkg.sv
// constants and types for the transmit line output stage
//******************************************************************
// Contract
// - line clock output is driven only while the line pins are enabled
// - line clock output runs at the DS3 or E3 line rate
// - coded modes: positive output high for each bit needing a positive pulse
// - coded modes: negative output high for each bit needing a negative pulse
// - unencoded mode: serial data bit appears on the shared positive/data output
// - outputs update on rising reference edge, falling edge when reference inverted
// - reference defaults to line clock; four other clocks are selectable
// - positive/data output can be disabled while the analog transmitter is on
// - line clock, positive/data and negative outputs each have own inversion
// - analog pair driven only when transmitter and its drive are enabled
// - one line bit per reference clock cycle at DS3 or E3 rate
// - line clock output usable as timing reference for framer-side signals
//******************************************************************
package tx_line_pkg;
   //******************************************************************
   // line rates
   //******************************************************************
   localparam int DS3_RATE_KHZ = 44736;
   localparam int E3_RATE_KHZ = 34368;
   localparam int CORE_CLK_KHZ = 50000;
   //******************************************************************
   // reference clock selection
   //******************************************************************
   localparam int NUM_REFS = 5;
   localparam logic [2:0] REF_LINE_CLK = 3'h0;
   localparam logic [2:0] REF_TX_CLOCK_OUT = 3'h1;
   localparam logic [2:0] REF_TX_CLOCK_IN = 3'h2;
   localparam logic [2:0] REF_RX_LINE_CLOCK_IN = 3'h3;
   localparam logic [2:0] REF_RX_CLOCK_OUT = 3'h4;
   //******************************************************************
   // symbol stream
   //******************************************************************
   localparam int SYM_W = 2;
   localparam int SYM_POS = 0;
   localparam int SYM_NEG = 1;
   localparam int FIFO_DEPTH = 8;
   localparam logic LINE_IDLE = 1'h0;
   typedef enum logic [1:0] {
      MODE_AMI,
      MODE_B3ZS,
      MODE_HDB3,
      MODE_UNI
   } line_mode_t;
endpackage

// ===== sym_fifo.sv
// flip-flop fifo carrying line symbols to the output stage
`timescale 1ns/1ps
module sym_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // fill side
   input wire logic i_wr_valid,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_wr_ready,
   // drain side
   output logic o_rd_valid,
   output logic [WIDTH-1:0] o_rd_data,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign o_wr_ready = (count_q != (AW+1)'(DEPTH));
   assign o_rd_valid = (count_q != '0);
   assign o_rd_data = mem_q[rd_ptr_q];
   assign push = i_wr_valid && o_wr_ready;
   assign pop = i_rd_ready && o_rd_valid;

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_wr_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         case ({push, pop})
            2'b10: count_q <= count_q + 1'b1;
            2'b01: count_q <= count_q - 1'b1;
            default: count_q <= count_q;
         endcase
      end
   end
endmodule

// ===== tx_line_interface_outputs.sv
// transmit line interface output stage: clock, pulse and analog enables
`timescale 1ns/1ps
module tx_line_interface_outputs
   import tx_line_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // configuration
   input wire line_mode_t i_line_mode,
   input wire logic i_e3_mode,
   input wire logic i_tx_line_pins_enable,
   input wire logic [2:0] i_ref_select,
   input wire logic i_ref_invert,
   input wire logic i_clk_out_invert,
   input wire logic i_pos_invert,
   input wire logic i_neg_invert,
   input wire logic i_analog_tx_enable,
   input wire logic i_analog_drive_enable,
   input wire logic i_pos_disable,
   // reference clock pins
   input wire logic i_line_rate_clk,
   input wire logic i_tx_clock_out,
   input wire logic i_tx_clock_in,
   input wire logic i_rx_line_clock_in,
   input wire logic i_rx_clock_out,
   // symbol stream from the encoder
   input wire logic i_sym_valid,
   input wire logic i_sym_pos,
   input wire logic i_sym_neg,
   output logic o_sym_ready,
   // line pins
   output logic o_tx_line_clock_out,
   output logic o_tx_positive_pulse_out,
   output logic o_tx_negative_pulse_out,
   // analog pair enables
   output logic o_tx_analog_plus,
   output logic o_tx_analog_plus_oe,
   output logic o_tx_analog_minus,
   output logic o_tx_analog_minus_oe,
   // status
   output logic o_line_clock_rise,
   output logic o_underrun,
   output logic [15:0] o_line_rate_khz
);
   //******************************************************************
   // reference clock sampling
   //******************************************************************
   logic [NUM_REFS-1:0] pin_raw;
   logic [NUM_REFS-1:0] sync1_q;
   logic [NUM_REFS-1:0] sync2_q;
   logic [NUM_REFS-1:0] sync3_q;
   logic [NUM_REFS-1:0] lvl_q;
   logic [NUM_REFS-1:0] lvl_prev_q;
   logic [NUM_REFS-1:0] agree;
   logic [NUM_REFS-1:0] rise;
   logic [NUM_REFS-1:0] fall;
   logic [2:0] sel_idx;
   logic sel_rise;
   logic sel_fall;
   logic sel_edge;

   assign pin_raw = {i_rx_clock_out, i_rx_line_clock_in, i_tx_clock_in,
                     i_tx_clock_out, i_line_rate_clk};
   // only the second and third stages are compared, the first stays private
   assign agree = sync2_q ~^ sync3_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         lvl_q <= '0;
         lvl_prev_q <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         lvl_q <= (lvl_q & ~agree) | (sync3_q & agree);
         lvl_prev_q <= lvl_q;
      end
   end

   assign rise = lvl_q & ~lvl_prev_q;
   assign fall = ~lvl_q & lvl_prev_q;

   // unknown selections fall back to the line clock
   always_comb begin
      case (i_ref_select)
         REF_TX_CLOCK_OUT: sel_idx = REF_TX_CLOCK_OUT;
         REF_TX_CLOCK_IN: sel_idx = REF_TX_CLOCK_IN;
         REF_RX_LINE_CLOCK_IN: sel_idx = REF_RX_LINE_CLOCK_IN;
         REF_RX_CLOCK_OUT: sel_idx = REF_RX_CLOCK_OUT;
         default: sel_idx = REF_LINE_CLK;
      endcase
   end

   assign sel_rise = rise[sel_idx];
   assign sel_fall = fall[sel_idx];
   assign sel_edge = i_ref_invert ? sel_fall : sel_rise;

   //******************************************************************
   // symbol buffer
   //******************************************************************
   logic rd_valid;
   logic [SYM_W-1:0] rd_sym;
   logic pop;
   logic uni_mode;

   // one symbol leaves per reference cycle, so the encoder is throttled to line rate
   assign pop = sel_edge && i_tx_line_pins_enable;
   assign uni_mode = (i_line_mode == MODE_UNI);

   sym_fifo #(
      .WIDTH(SYM_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_wr_valid(i_sym_valid),
      .i_wr_data({i_sym_neg, i_sym_pos}),
      .o_wr_ready(o_sym_ready),
      .o_rd_valid(rd_valid),
      .o_rd_data(rd_sym),
      .i_rd_ready(pop)
   );

   //******************************************************************
   // bit registers, loaded on the selected edge
   //******************************************************************
   logic pos_bit_q;
   logic neg_bit_q;
   logic underrun_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         pos_bit_q <= LINE_IDLE;
         neg_bit_q <= LINE_IDLE;
      end else if (!i_tx_line_pins_enable) begin
         pos_bit_q <= LINE_IDLE;
         neg_bit_q <= LINE_IDLE;
      end else if (pop) begin
         // an empty buffer sends a zero rather than repeating a stale pulse
         pos_bit_q <= rd_valid && rd_sym[SYM_POS];
         neg_bit_q <= rd_valid && rd_sym[SYM_NEG] && !uni_mode;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         underrun_q <= 1'b0;
      end else begin
         underrun_q <= pop && !rd_valid;
      end
   end

   assign o_underrun = underrun_q;

   //******************************************************************
   // pin drivers
   //******************************************************************
   logic clk_out_q;
   logic pos_out_q;
   logic neg_out_q;
   logic pos_kill;
   logic clk_next;
   logic pos_next;
   logic neg_next;

   assign pos_kill = i_analog_tx_enable && i_pos_disable;
   assign clk_next = lvl_q[REF_LINE_CLK] ^ i_clk_out_invert;
   assign pos_next = pos_bit_q ^ i_pos_invert;
   assign neg_next = neg_bit_q ^ i_neg_invert;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         clk_out_q <= LINE_IDLE;
         pos_out_q <= LINE_IDLE;
         neg_out_q <= LINE_IDLE;
      end else begin
         // line clock is the rate source forwarded at DS3 or E3 frequency
         clk_out_q <= i_tx_line_pins_enable ? clk_next : LINE_IDLE;
         pos_out_q <= (i_tx_line_pins_enable && !pos_kill) ? pos_next : LINE_IDLE;
         neg_out_q <= i_tx_line_pins_enable ? neg_next : LINE_IDLE;
      end
   end

   assign o_tx_line_clock_out = clk_out_q;
   assign o_tx_positive_pulse_out = pos_out_q;
   assign o_tx_negative_pulse_out = neg_out_q;

   //******************************************************************
   // analog transmit pair
   //******************************************************************
   logic analog_drive;
   logic ana_plus_q;
   logic ana_minus_q;
   logic ana_oe_q;
   logic rise_q;

   assign analog_drive = i_analog_tx_enable && i_analog_drive_enable;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ana_plus_q <= LINE_IDLE;
         ana_minus_q <= LINE_IDLE;
         ana_oe_q <= 1'b0;
      end else begin
         ana_oe_q <= analog_drive;
         ana_plus_q <= analog_drive && pos_bit_q;
         ana_minus_q <= analog_drive && neg_bit_q;
      end
   end

   assign o_tx_analog_plus = ana_plus_q;
   assign o_tx_analog_minus = ana_minus_q;
   assign o_tx_analog_plus_oe = ana_oe_q;
   assign o_tx_analog_minus_oe = ana_oe_q;

   // framer-side logic may time itself from this strobe instead of a pin
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rise_q <= 1'b0;
      end else begin
         rise_q <= rise[REF_LINE_CLK] && i_tx_line_pins_enable;
      end
   end

   assign o_line_clock_rise = rise_q;
   // nominal rate reported for the selected standard
   assign o_line_rate_khz = i_e3_mode ? 16'(E3_RATE_KHZ) : 16'(DS3_RATE_KHZ);

   //******************************************************************
   // assertions
   //******************************************************************
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_pos_sym;
      pop && rd_valid && rd_sym[SYM_POS];
   endsequence

   sequence s_neg_sym;
      pop && rd_valid && rd_sym[SYM_NEG] && !uni_mode;
   endsequence

   sequence s_pos_open;
      i_tx_line_pins_enable && !pos_kill && !i_pos_invert;
   endsequence

   sequence s_neg_open;
      i_tx_line_pins_enable && !i_neg_invert;
   endsequence

   clock_gated_a: assert property (
      !i_tx_line_pins_enable |=> !o_tx_line_clock_out
   ) else $error("line clock driven while pins disabled");

   quiet_pins_a: assert property (
      !i_tx_line_pins_enable ##1 !i_tx_line_pins_enable
         |=> !o_tx_positive_pulse_out && !o_tx_negative_pulse_out
   ) else $error("pulse outputs not idle while pins disabled");

   clock_follow_a: assert property (
      i_tx_line_pins_enable |=> o_tx_line_clock_out == $past(clk_next)
   ) else $error("line clock does not follow rate source");

   pos_pulse_a: assert property (
      s_pos_sym ##1 s_pos_open |=> o_tx_positive_pulse_out
   ) else $error("positive pulse missing");

   neg_pulse_a: assert property (
      s_neg_sym ##1 s_neg_open |=> o_tx_negative_pulse_out
   ) else $error("negative pulse missing");

   uni_no_neg_a: assert property (
      pop && uni_mode |=> !neg_bit_q
   ) else $error("negative output active in unencoded mode");

   edge_pick_a: assert property (
      sel_rise && i_ref_invert |-> !sel_edge
   ) else $error("inverted reference updated on rising edge");

   one_per_edge_a: assert property (
      !sel_edge |-> !pop
   ) else $error("symbol taken without reference edge");

   pos_disable_a: assert property (
      pos_kill |=> !o_tx_positive_pulse_out
   ) else $error("positive output driven while disabled");

   analog_off_a: assert property (
      !analog_drive |=> !o_tx_analog_plus_oe && !o_tx_analog_minus_oe && !o_tx_analog_plus
   ) else $error("analog pair driven while disabled");

   ref_default_a: assert property (
      i_ref_select > REF_RX_CLOCK_OUT |-> sel_idx == REF_LINE_CLK
   ) else $error("unknown selection not routed to line clock");
endmodule

// ===== line_rx_model.sv
// far-side line receiver model: one captured symbol per line clock period
`timescale 1ns/1ps
module line_rx_model (
   // line pins
   input wire logic i_line_clk,
   input wire logic i_pos,
   input wire logic i_neg,
   // receiver configuration
   input wire logic i_clk_invert
);
   //******************************************************************
   // capture
   //******************************************************************
   logic [1:0] cap[$];
   wire logic eff_clk = i_line_clk ^ i_clk_invert;
   // sample on the trailing half, well away from the data update unless the reference is inverted, when it falls one core cycle before it
   always @(negedge eff_clk) begin
      cap.push_back({i_neg, i_pos});
   end
endmodule

// ===== test_tx_line_interface_outputs.sv
// self-checking bench for the transmit line output stage
`timescale 1ns/1ps
module test_tx_line_interface_outputs;
   import tx_line_pkg::*;
   //******************************************************************
   // signals
   //******************************************************************
   logic clk, rst_n, lclk, e3, en, rinv, cinv, pinv, ninv, aen, den, pdis;
   logic valid, spos, sneg, ready, o_clk, o_pos, o_neg, ap, ap_oe, an, an_oe;
   logic rise, underrun;
   logic [15:0] khz;
   logic [2:0] sel;
   line_mode_t mode;
   int fails, checks, cnt, hi, lo;
   logic [1:0] exp_q[$];
   logic [3:0] pat = 4'hD;
   logic [7:0] pat8 = 8'hB4;
   typedef struct packed {
      line_mode_t m;
      logic [2:0] s;
      logic ri, ci, pi, ni;
   } row_t;
   row_t rows[6];
   // besides the line clock, only the selected alternate reference pin toggles, so a wrong alternate select starves the line
   wire logic r_txo = lclk & (sel == 3'h1);
   wire logic r_txi = lclk & (sel == 3'h2);
   wire logic r_rxl = lclk & (sel == 3'h3);
   wire logic r_rxo = lclk & (sel == 3'h4);
   //******************************************************************
   // clocks, design and far side
   //******************************************************************
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   initial begin
      lclk = 1'h0;
      #7;
      forever #80 lclk = ~lclk;
   end
   tx_line_interface_outputs dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_line_mode(mode),
      .i_e3_mode(e3), .i_tx_line_pins_enable(en), .i_ref_select(sel), .i_ref_invert(rinv),
      .i_clk_out_invert(cinv), .i_pos_invert(pinv), .i_neg_invert(ninv),
      .i_analog_tx_enable(aen), .i_analog_drive_enable(den), .i_pos_disable(pdis),
      .i_line_rate_clk(lclk), .i_tx_clock_out(r_txo), .i_tx_clock_in(r_txi),
      .i_rx_line_clock_in(r_rxl), .i_rx_clock_out(r_rxo), .i_sym_valid(valid),
      .i_sym_pos(spos), .i_sym_neg(sneg), .o_sym_ready(ready), .o_tx_line_clock_out(o_clk),
      .o_tx_positive_pulse_out(o_pos), .o_tx_negative_pulse_out(o_neg),
      .o_tx_analog_plus(ap), .o_tx_analog_plus_oe(ap_oe), .o_tx_analog_minus(an),
      .o_tx_analog_minus_oe(an_oe), .o_line_clock_rise(rise), .o_underrun(underrun),
      .o_line_rate_khz(khz));
   line_rx_model lp (.i_line_clk(o_clk), .i_pos(o_pos), .i_neg(o_neg), .i_clk_invert(cinv));
   //******************************************************************
   // tasks
   //******************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic push(input logic p, input logic n);
      @(posedge clk);
      valid <= 1'h1;
      spos <= p;
      sneg <= n;
   endtask
   task automatic idle();
      @(posedge clk);
      valid <= 1'h0;
   endtask
   // contiguous search, since idle zeros precede the pushed symbols
   function automatic logic found();
      logic ok;
      found = 1'h0;
      for (int i = 0; i + exp_q.size() <= lp.cap.size(); i++) begin
         ok = 1'h1;
         for (int k = 0; k < exp_q.size(); k++) if (lp.cap[i+k] !== exp_q[k]) ok = 1'h0;
         if (ok) found = 1'h1;
      end
   endfunction
   task automatic conclude();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      cyc(100000);
      fails++;
      conclude();
   end
   //******************************************************************
   // main sequence
   //******************************************************************
   initial begin
      rows = '{'{MODE_AMI, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0}, '{MODE_B3ZS, 3'h1, 1'h1, 1'h0, 1'h0, 1'h0},
         '{MODE_HDB3, 3'h2, 1'h0, 1'h0, 1'h1, 1'h0}, '{MODE_UNI, 3'h3, 1'h0, 1'h0, 1'h0, 1'h1},
         '{MODE_AMI, 3'h4, 1'h0, 1'h1, 1'h0, 1'h0}, '{MODE_UNI, 3'h5, 1'h1, 1'h0, 1'h1, 1'h0}};
      {rst_n, e3, en, rinv, cinv, pinv, ninv, aen, den, pdis, valid, spos, sneg} = 13'h0;
      sel = 3'h0;
      mode = MODE_AMI;
      cyc(2);
      rst_n <= 1'h1;
      @(negedge clk);
      chk({ready, o_clk, o_pos, o_neg, ap_oe, an_oe}, 16'h20);
      chk(khz, 16'(DS3_RATE_KHZ));
      cyc(6);
      for (int r = 0; r < 6; r++) begin
         @(posedge clk);
         mode <= rows[r].m;
         sel <= rows[r].s;
         rinv <= rows[r].ri;
         cinv <= rows[r].ci;
         pinv <= rows[r].pi;
         ninv <= rows[r].ni;
         en <= 1'h1;
         cyc(40);
         lp.cap.delete();
         exp_q.delete();
         for (int k = 0; k < 4; k++) begin
            push(pat[k], ~pat[k]);
            exp_q.push_back({(rows[r].m == MODE_UNI ? 1'h0 : ~pat[k]) ^ rows[r].ni,
               pat[k] ^ rows[r].pi});
         end
         idle();
         cyc(120);
         chk(16'(found()), 16'h1);
      end
      // line rate: one rise per 8 core cycles at the bench line clock
      cnt = 0;
      repeat (1600) begin
         @(posedge clk);
         if (rise === 1'h1) cnt++;
      end
      chk(16'(cnt > 198 && cnt < 202), 16'h1);
      e3 <= 1'h1;
      cyc(2);
      chk(khz, 16'(E3_RATE_KHZ));
      // pins off: static low despite inversion, and the fifo holds its symbols
      {en, sel, rinv, cinv, pinv, ninv} <= 8'h07;
      mode <= MODE_UNI;
      cyc(10);
      cnt = 0;
      repeat (16) begin
         @(negedge clk);
         if (o_clk | o_pos | o_neg | rise) cnt++;
      end
      chk(16'(cnt), 16'h0);
      exp_q.delete();
      for (int k = 0; k < 9; k++) begin
         push(k < 8 ? pat8[k] : 1'h1, 1'h0);
         if (k < 8) exp_q.push_back({1'h0, pat8[k]});
      end
      exp_q.push_back(2'h0);
      @(negedge clk);
      chk(16'(ready), 16'h0);
      idle();
      {cinv, pinv, ninv, en} <= 4'h1;
      lp.cap.delete();
      cyc(150);
      chk(16'(found()), 16'h1);
      cnt = 0;
      for (int w = 0; w < 40 && cnt == 0; w++) begin
         @(posedge clk);
         if (underrun === 1'h1) cnt = 1;
      end
      chk(16'(cnt), 16'h1);
      for (int a = 0; a < 4; a++) begin
         aen <= a[0];
         den <= a[1];
         cyc(4);
         chk({ap_oe, an_oe}, {14'h0, {2{a[0] & a[1]}}});
      end
      // positive output suppressed while the analog transmitter carries the line
      pdis <= 1'h1;
      lp.cap.delete();
      for (int k = 0; k < 4; k++) push(1'h1, 1'h0);
      idle();
      // the analog pair still carries the data bits that the pin no longer shows
      hi = 0;
      lo = 0;
      repeat (80) begin
         @(negedge clk);
         if (ap === 1'h1) hi++;
         if (an !== 1'h0) lo++;
      end
      chk(16'(hi > 0), 16'h1);
      chk(16'(lo), 16'h0);
      cnt = 0;
      foreach (lp.cap[i]) if (lp.cap[i][0] !== 1'h0) cnt++;
      chk(16'(cnt), 16'h0);
      // reset in mid-run with pins and analog drive enabled
      @(posedge clk);
      rst_n <= 1'h0;
      cyc(2);
      rst_n <= 1'h1;
      @(negedge clk);
      chk({ready, o_clk, o_pos, o_neg, ap_oe, an_oe}, 16'h20);
      conclude();
   end
endmodule
